// file: src/bcm_pkg.sv
// Function
// [RULE1] high/low pair read returns one sample
// [RULE2] optional CRC-8 follows every read byte
// [RULE3] converter codes are unsigned 14 bits
// [RULE4] converter runs only while enable bit set
// [RULE5] normal-state entry sets converter enable itself
// [RULE6] cell high/low checks need converter enabled
// [RULE7] 50 ms per cell, 250 ms full set; code repeats a 50 ms-window set every 500 ms
// [RULE8] all five-cell groups measured in parallel
// [RULE9] stack sum of all cells readable
// [RULE10] faults raise alert, turn off FET drive
// [RULE11] only host re-enables FET drives after fault
// [RULE12] alert reports faults and integrator ready
// [RULE13] externally forced alert cuts both FET drives; code detects it only while its own alert output is low
// [RULE14] detect high, low, overcurrent, short, external, device
// [RULE15] all data exchanged through register reads/writes
// [RULE16] balancing group uses 12.5 ms cell window
// [RULE17] results right-aligned, high byte first pair; the stack sum pair holds only the top 16 of its 18 bits
package bcm_pkg;
	localparam int ADC_W = 14;
	localparam int ADC_LSB_UV = 382;
	localparam int ADC_FS_MV = 6275;
	localparam int CC_W = 16;
	localparam int SUM_W = 18;
	localparam int CELLS_PER_GROUP = 5;
	localparam int CLK_MHZ = 250;
	localparam int STD_WIN_US = 50000;
	localparam int BAL_WIN_US = 12500;
	localparam int FRAME_US = 250000;
	localparam int STD_WIN_CYCLES = STD_WIN_US * CLK_MHZ;
	localparam int BAL_WIN_CYCLES = BAL_WIN_US * CLK_MHZ;
	localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;
	// status bit positions
	localparam int ST_HIGH = 0;
	localparam int ST_LOW = 1;
	localparam int ST_OCD = 2;
	localparam int ST_SHORT = 3;
	localparam int ST_EXT = 4;
	localparam int ST_DEVF = 5;
	localparam int ST_CCRDY = 6;
	localparam int STATUS_W = 7;
	// register indices on the host link
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CC_HI = 8'h02;
	localparam logic [7:0] REG_SUM_HI = 8'h04;
	localparam logic [7:0] REG_CELL_BASE = 8'h0c;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [STATUS_W-1:0] STATUS_RESET = 7'h00;
	typedef enum logic {SEQ_IDLE, SEQ_MEASURE} bcm_seq_t;
endpackage : bcm_pkg

// file: src/bcm_readout.sv
`timescale 1ns/1ps
module bcm_readout import bcm_pkg::*; #(
	parameter int NUM_GROUPS = 3,
	parameter int STD_WIN_CYC = STD_WIN_CYCLES,
	parameter int BAL_WIN_CYC = BAL_WIN_CYCLES,
	parameter int FRAME_CYC = FRAME_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic normalEntry,
	input wire logic adcEnableWr,
	input wire logic adcEnableVal,
	input wire logic [NUM_GROUPS*CELLS_PER_GROUP-1:0] balanceGroup,
	input wire logic [NUM_GROUPS*ADC_W-1:0] adcCode,
	output logic [NUM_GROUPS*3-1:0] adcCellSel,
	output logic [NUM_GROUPS-1:0] adcBusy,
	output logic adcEnable,
	input wire logic [ADC_W-1:0] cellHighLimit,
	input wire logic [ADC_W-1:0] cellLowLimit,
	input wire logic dischargeOvercurrent,
	input wire logic dischargeShort,
	input wire logic deviceFaultFlag,
	input wire logic ccDone,
	input wire logic [CC_W-1:0] ccCode,
	input wire logic chargeFetSet,
	input wire logic dischargeFetSet,
	output logic chargeFetDrive,
	output logic dischargeFetDrive,
	input wire logic [STATUS_W-1:0] statusClear,
	output logic [STATUS_W-1:0] status,
	output logic [SUM_W-1:0] stackSum,
	input wire logic alertIn,
	output logic alertOut,
	output logic alertOe,
	input wire logic crcEn,
	input wire logic rdStart,
	input wire logic [7:0] rdAddr,
	input wire logic rdNext,
	input wire logic rdStop,
	output logic [7:0] rdData,
	output logic [7:0] rdCrc,
	output logic rdValid
);
	localparam int NUM_CELLS = NUM_GROUPS * CELLS_PER_GROUP;
	localparam logic [2:0] LAST_CELL = 3'(CELLS_PER_GROUP - 1);
	logic [31:0] frameCnt, next_frameCnt;
	logic frameTick, next_adcEnable;
	logic [NUM_CELLS*ADC_W-1:0] cellFlat;
	logic [NUM_GROUPS-1:0] highHit, lowHit;
	// converter enable: host write, forced on at normal-state entry
	always_comb begin
		next_adcEnable = adcEnable;
		if (adcEnableWr) next_adcEnable = adcEnableVal; // [RULE4]
		if (normalEntry) next_adcEnable = 1'b1; // [RULE5]
	end
	// frame tick every 250 ms restarts each idle group; a group on 50 ms windows is still busy then and restarts every 500 ms
	assign frameTick = adcEnable && (frameCnt == 32'h0); // [RULE7]
	always_comb begin
		if (!adcEnable || frameCnt == 32'(FRAME_CYC - 1)) next_frameCnt = 32'h0;
		else next_frameCnt = frameCnt + 32'h1;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			adcEnable <= 1'b0;
			frameCnt <= 32'h0;
		end else begin
			adcEnable <= next_adcEnable;
			frameCnt <= next_frameCnt;
		end
	end
	// one sequencer per group, all started by the same tick
	for (genvar g = 0; g < NUM_GROUPS; g++) begin : gGroup
		bcm_seq_t seqState, next_seqState;
		logic [2:0] cellIdx, next_cellIdx;
		logic [31:0] winCnt, next_winCnt, winLen;
		logic [ADC_W-1:0] code;
		logic [ADC_W-1:0] res [CELLS_PER_GROUP];
		logic sampleNow;
		assign code = adcCode[g*ADC_W +: ADC_W]; // [RULE3]
		// short window while balancing; >= still ends a window that shrank mid-cell
		assign winLen = (|balanceGroup[g*CELLS_PER_GROUP +: CELLS_PER_GROUP]) ?
			32'(BAL_WIN_CYC) : 32'(STD_WIN_CYC); // [RULE16]
		assign sampleNow = (seqState == SEQ_MEASURE) && (winCnt >= winLen - 32'h1);
		assign adcBusy[g] = (seqState == SEQ_MEASURE);
		assign adcCellSel[g*3 +: 3] = cellIdx;
		// limit checks only see samples taken while enabled
		assign highHit[g] = sampleNow && adcEnable && (code > cellHighLimit); // [RULE6]
		assign lowHit[g] = sampleNow && adcEnable && (code < cellLowLimit); // [RULE6]
		for (genvar c = 0; c < CELLS_PER_GROUP; c++) begin : gCell
			assign cellFlat[(g*CELLS_PER_GROUP+c)*ADC_W +: ADC_W] = res[c];
		end
		always_comb begin
			next_seqState = seqState;
			next_cellIdx = cellIdx;
			next_winCnt = winCnt;
			case (seqState)
				SEQ_IDLE: begin
					if (frameTick) begin // [RULE8]
						next_seqState = SEQ_MEASURE;
						next_cellIdx = 3'h0;
						next_winCnt = 32'h0;
					end
				end
				SEQ_MEASURE: begin
					if (!adcEnable) next_seqState = SEQ_IDLE; // [RULE4]
					else if (sampleNow) begin // [RULE7]
						next_winCnt = 32'h0;
						if (cellIdx == LAST_CELL) next_seqState = SEQ_IDLE;
						else next_cellIdx = cellIdx + 3'h1;
					end else begin
						next_winCnt = winCnt + 32'h1;
					end
				end
				default: next_seqState = SEQ_IDLE;
			endcase
		end
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				seqState <= SEQ_IDLE;
				cellIdx <= 3'h0;
				winCnt <= 32'h0;
				for (int c = 0; c < CELLS_PER_GROUP; c++) res[c] <= '0;
			end else begin
				seqState <= next_seqState;
				cellIdx <= next_cellIdx;
				winCnt <= next_winCnt;
				if (sampleNow) res[cellIdx] <= code;
			end
		end
	end
	// stack sum, rebuilt every cycle from the stored results
	logic [SUM_W-1:0] next_stackSum;
	always_comb begin
		next_stackSum = '0;
		for (int i = 0; i < NUM_CELLS; i++) begin
			next_stackSum = next_stackSum + SUM_W'(cellFlat[i*ADC_W +: ADC_W]); // [RULE9]
		end
	end
	// fault events, sticky status and FET drives
	logic [STATUS_W-1:0] events, next_status;
	logic extFault, chargeOff, dischargeOff, next_chargeFet, next_dischargeFet;
	logic [CC_W-1:0] ccHold, next_ccHold;
	// pin reads high while we pull it low: secondary protector tripped
	assign extFault = alertIn && !alertOut; // [RULE13]
	always_comb begin
		events = '0;
		events[ST_HIGH] = |highHit; // [RULE14]
		events[ST_LOW] = |lowHit; // [RULE14]
		events[ST_OCD] = dischargeOvercurrent; // [RULE14]
		events[ST_SHORT] = dischargeShort; // [RULE14]
		events[ST_EXT] = extFault; // [RULE14]
		events[ST_DEVF] = deviceFaultFlag; // [RULE14]
		events[ST_CCRDY] = ccDone; // [RULE12]
		// a new event beats a clear in the same cycle
		next_status = (status & ~statusClear) | events;
		chargeOff = next_status[ST_HIGH] | next_status[ST_EXT] | next_status[ST_DEVF];
		dischargeOff = next_status[ST_LOW] | next_status[ST_OCD] | next_status[ST_SHORT] |
			next_status[ST_EXT] | next_status[ST_DEVF]; // [RULE10]
		// a fault, or a flag the host has not cleared yet, wins over a host set
		next_chargeFet = (chargeFetDrive | chargeFetSet) & ~chargeOff; // [RULE11]
		next_dischargeFet = (dischargeFetDrive | dischargeFetSet) & ~dischargeOff; // [RULE11]
		next_ccHold = ccDone ? ccCode : ccHold;
	end
	assign alertOut = |status; // [RULE12]
	assign alertOe = 1'b1;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status <= STATUS_RESET;
			chargeFetDrive <= 1'b0;
			dischargeFetDrive <= 1'b0;
			ccHold <= '0;
			stackSum <= '0;
		end else begin
			status <= next_status;
			chargeFetDrive <= next_chargeFet;
			dischargeFetDrive <= next_dischargeFet;
			ccHold <= next_ccHold;
			stackSum <= next_stackSum;
		end
	end
	// register read path with auto-increment and pair snapshot
	function automatic logic [7:0] crc8(input logic [7:0] b);
		logic [7:0] c;
		c = b;
		for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		return c;
	endfunction : crc8
	logic [7:0] rdPtr, next_rdPtr, snapLow, next_snapLow, snapAddr, next_snapAddr;
	logic [7:0] next_rdData, next_rdCrc, curByte, pairOfs;
	logic snapValid, next_snapValid, isPair;
	logic [15:0] pairWord;
	always_comb begin
		pairWord = 16'h0;
		isPair = 1'b1;
		pairOfs = {rdPtr[7:1], 1'b0};
		if (pairOfs == REG_CC_HI) pairWord = ccHold;
		else if (pairOfs == REG_SUM_HI) pairWord = stackSum[SUM_W-1:SUM_W-16];
		else isPair = 1'b0;
		for (int i = 0; i < NUM_CELLS; i++) begin
			if (pairOfs == REG_CELL_BASE + 8'(2 * i)) begin
				pairWord = {2'b00, cellFlat[i*ADC_W +: ADC_W]}; // [RULE17]
				isPair = 1'b1;
			end
		end
		if (rdPtr == REG_STATUS) curByte = {1'b0, status}; // [RULE15]
		else if (!isPair) curByte = 8'h00;
		else if (rdPtr[0] && snapValid && rdPtr == snapAddr) curByte = snapLow; // [RULE1]
		else curByte = rdPtr[0] ? pairWord[7:0] : pairWord[15:8]; // [RULE17]
		next_rdPtr = rdPtr;
		next_snapLow = snapLow;
		next_snapAddr = snapAddr;
		next_snapValid = snapValid;
		next_rdData = rdData;
		next_rdCrc = rdCrc;
		if (rdStart || rdStop) begin
			next_rdPtr = rdAddr;
			next_snapValid = 1'b0;
		end else if (rdNext) begin
			next_rdData = curByte;
			next_rdCrc = crcEn ? crc8(curByte) : 8'h00; // [RULE2]
			next_rdPtr = rdPtr + 8'h1;
			// freeze the low half when its high half goes out
			next_snapValid = isPair && !rdPtr[0]; // [RULE1]
			next_snapLow = pairWord[7:0];
			next_snapAddr = rdPtr + 8'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdPtr <= 8'h0;
			snapLow <= 8'h0;
			snapAddr <= 8'h0;
			snapValid <= 1'b0;
			rdData <= 8'h0;
			rdCrc <= 8'h0;
			rdValid <= 1'b0;
		end else begin
			rdPtr <= next_rdPtr;
			snapLow <= next_snapLow;
			snapAddr <= next_snapAddr;
			snapValid <= next_snapValid;
			rdData <= next_rdData;
			rdCrc <= next_rdCrc;
			rdValid <= rdNext && !rdStart && !rdStop;
		end
	end
	property p_read_answer;
		@(posedge clk) disable iff (!rst_n) rdNext && !rdStart && !rdStop |=> rdValid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read byte not answered"); // [RULE15]
	property p_crc_off;
		@(posedge clk) disable iff (!rst_n) rdValid && !$past(crcEn) |-> rdCrc == 8'h00;
	endproperty
	a_crc_off: assert property (p_crc_off) else $error("crc byte while crc off"); // [RULE2]
	property p_atomic;
		@(posedge clk) disable iff (!rst_n)
			rdNext && snapValid && rdPtr == snapAddr && !rdStart && !rdStop |=> rdData == $past(snapLow);
	endproperty
	a_atomic: assert property (p_atomic) else $error("low byte not from snapshot"); // [RULE1]
	property p_idle_off;
		@(posedge clk) disable iff (!rst_n)
			!adcEnable |-> (!(|highHit) && !(|lowHit) && !frameTick) ##1 (adcBusy == '0);
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("converter active while disabled"); // [RULE4]
	property p_normal_on;
		@(posedge clk) disable iff (!rst_n) normalEntry |=> adcEnable;
	endproperty
	a_normal_on: assert property (p_normal_on) else $error("normal entry left converter off"); // [RULE5]
	property p_checks_need_adc;
		@(posedge clk) disable iff (!rst_n) (|highHit) || (|lowHit) |-> adcEnable;
	endproperty
	a_checks_need_adc: assert property (p_checks_need_adc) else $error("limit check while off"); // [RULE6]
	property p_parallel;
		@(posedge clk) disable iff (!rst_n) frameTick |=> adcBusy == {NUM_GROUPS{1'b1}} || !adcEnable;
	endproperty
	a_parallel: assert property (p_parallel) else $error("groups did not start together"); // [RULE8]
	property p_frame;
		@(posedge clk) disable iff (!rst_n) frameTick ##1 adcEnable |-> frameCnt == 32'h1;
	endproperty
	a_frame: assert property (p_frame) else $error("frame counter did not advance"); // [RULE7]
	property p_high_cuts_charge;
		@(posedge clk) disable iff (!rst_n) (|highHit) |=> !chargeFetDrive && status[ST_HIGH];
	endproperty
	a_high_cuts_charge: assert property (p_high_cuts_charge) else $error("charge kept on"); // [RULE10]
	property p_ext_cuts_both;
		@(posedge clk) disable iff (!rst_n) extFault |=> !chargeFetDrive && !dischargeFetDrive;
	endproperty
	a_ext_cuts_both: assert property (p_ext_cuts_both) else $error("external fault ignored"); // [RULE13]
	property p_no_self_restore;
		@(posedge clk) disable iff (!rst_n) $rose(dischargeFetDrive) |-> $past(dischargeFetSet);
	endproperty
	a_no_self_restore: assert property (p_no_self_restore) else $error("drive restored alone"); // [RULE11]
	property p_cc_alert;
		@(posedge clk) disable iff (!rst_n) ccDone |=> alertOut && status[ST_CCRDY];
	endproperty
	a_cc_alert: assert property (p_cc_alert) else $error("integrator ready not flagged"); // [RULE12]
	c_frame: cover property (@(posedge clk) disable iff (!rst_n) frameTick ##1 adcBusy[0]);
	c_fault: cover property (@(posedge clk) disable iff (!rst_n) extFault ##1 alertOut);
	c_pair: cover property (@(posedge clk) disable iff (!rst_n) rdNext ##1 rdNext && snapValid);
endmodule : bcm_readout

// file: verification/bcm_host.sv
`timescale 1ns/1ps
// host side of the read link; every value comes back as register bytes
module bcm_host (
	input wire logic clk,
	input wire logic [7:0] rdData,
	input wire logic [7:0] rdCrc,
	input wire logic rdValid,
	output logic rdStart,
	output logic [7:0] rdAddr,
	output logic rdNext,
	output logic rdStop
);
	initial begin
		rdStart = 1'b0;
		rdAddr = 8'h00;
		rdNext = 1'b0;
		rdStop = 1'b0;
	end
	// address goes to its inverse once released, so a stale pointer never looks valid
	task automatic start(input logic [7:0] a);
		@(negedge clk) rdStart = 1'b1;
		rdAddr = a;
		@(negedge clk) rdStart = 1'b0;
		rdAddr = ~a;
	endtask : start
	// one byte and its check byte, read mid-cycle while rdValid stands
	task automatic next(output logic [7:0] d, output logic [7:0] c, output logic v);
		@(negedge clk) rdNext = 1'b1;
		@(negedge clk) rdNext = 1'b0;
		v = rdValid;
		d = rdData;
		c = rdCrc;
	endtask : next
	task automatic stop();
		@(negedge clk) rdStop = 1'b1;
		@(negedge clk) rdStop = 1'b0;
	endtask : stop
endmodule : bcm_host

// file: verification/tb.sv
`timescale 1ns/1ps
module tb import bcm_pkg::*;;
	localparam int NG = 3;
	localparam int FR = 120;
	logic clk = 1'b0, rst_n = 1'b0, normalEntry = 1'b0, adcEnableWr = 1'b0, adcEnableVal = 1'b0;
	logic [NG*5-1:0] balanceGroup = '0;
	logic [NG*ADC_W-1:0] adcCode = '0;
	logic [NG*3-1:0] adcCellSel;
	logic [NG-1:0] adcBusy;
	logic adcEnable, chargeFetDrive, dischargeFetDrive, alertOut, alertOe, rdValid, v;
	logic rdStart, rdNext, rdStop, extDrv = 1'b0, crcEn = 1'b0, ccDone = 1'b0;
	logic dischargeOvercurrent = 1'b0, dischargeShort = 1'b0, deviceFaultFlag = 1'b0;
	logic chargeFetSet = 1'b0, dischargeFetSet = 1'b0;
	logic [ADC_W-1:0] cellHighLimit = 14'h3fff, cellLowLimit = 14'h0000;
	logic [ADC_W-1:0] base [NG];
	logic [CC_W-1:0] ccCode = 16'h0000, ccOld;
	logic [STATUS_W-1:0] statusClear = '0, status;
	logic [SUM_W-1:0] stackSum, sum;
	logic [7:0] rdAddr, rdData, rdCrc, d, c;
	int mismatches = 0, cmp_count = 0, seed, c0, c1;
	int ks [6] = '{ST_HIGH, ST_LOW, ST_OCD, ST_SHORT, ST_EXT, ST_DEVF};
	time t0;
	wire logic alertIn;
	// open-drain alert: our drive or the external protector pulls it high
	assign alertIn = (alertOe & alertOut) | extDrv;
	always #2 clk = ~clk;
	// each cell gets its own code so a misplaced result shows up
	always @(negedge clk) begin
		for (int g = 0; g < NG; g++) adcCode[g*ADC_W+:ADC_W] <= base[g] + {11'h000, adcCellSel[g*3+:3]};
	end
	bcm_readout #(.NUM_GROUPS(NG), .STD_WIN_CYC(20), .BAL_WIN_CYC(5), .FRAME_CYC(FR)) dut (
		.clk, .rst_n, .normalEntry, .adcEnableWr, .adcEnableVal, .balanceGroup, .adcCode,
		.adcCellSel, .adcBusy, .adcEnable, .cellHighLimit, .cellLowLimit, .dischargeOvercurrent,
		.dischargeShort, .deviceFaultFlag, .ccDone, .ccCode, .chargeFetSet, .dischargeFetSet,
		.chargeFetDrive, .dischargeFetDrive, .statusClear, .status, .stackSum, .alertIn,
		.alertOut, .alertOe, .crcEn, .rdStart, .rdAddr, .rdNext, .rdStop, .rdData, .rdCrc, .rdValid);
	bcm_host host (.clk, .rdData, .rdCrc, .rdValid, .rdStart, .rdAddr, .rdNext, .rdStop);
	function automatic logic [7:0] crc8(input logic [7:0] b);
		logic [7:0] r;
		r = b;
		for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ CRC_POLY : {r[6:0], 1'b0};
		return r;
	endfunction : crc8
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
		end
	endtask : check
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	// bounded wait on group zero's busy level; running out ends the run
	task automatic waitBusy(input logic lvl);
		int n;
		n = 0;
		while (adcBusy[0] !== lvl && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (n == 400) begin
			mismatches++;
			close_out();
		end
	endtask : waitBusy
	// high byte then low byte in one transaction
	task automatic rp(input logic [7:0] a, input logic [15:0] e);
		host.start(a);
		for (int b = 1; b >= 0; b--) begin
			host.next(d, c, v);
			check(v, 1'b1, "valid");
			check(d, e[b*8+:8], "byte");
			check(c, crcEn ? crc8(e[b*8+:8]) : 8'h00, "crc");
		end
		host.stop();
	endtask : rp
	task automatic fetSet();
		@(negedge clk) chargeFetSet = 1'b1;
		dischargeFetSet = 1'b1;
		@(negedge clk) chargeFetSet = 1'b0;
		dischargeFetSet = 1'b0;
	endtask : fetSet
	task automatic inject(input int k, input logic on);
		case (k)
			ST_HIGH: cellHighLimit = on ? 14'h0000 : 14'h3fff;
			ST_LOW: cellLowLimit = on ? 14'h3fff : 14'h0000;
			ST_OCD: dischargeOvercurrent = on;
			ST_SHORT: dischargeShort = on;
			ST_EXT: extDrv = on;
			default: deviceFaultFlag = on;
		endcase
	endtask : inject
	initial begin
		seed = $urandom(32'h2ac2926b);
		for (int g = 0; g < NG; g++) base[g] = 14'($urandom) & 14'h3ff0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		check({status, adcEnable, chargeFetDrive, alertOe}, 10'h001, "reset");
		@(negedge clk) normalEntry = 1'b1;
		@(negedge clk) normalEntry = 1'b0;
		check(adcEnable, 1'b1, "auto enable");
		waitBusy(1);
		check({adcBusy, adcCellSel}, {3'b111, 9'h000}, "groups together");
		waitBusy(0);
		sum = '0;
		// every cell result, right-aligned 14-bit code
		for (int i = 0; i < NG * 5; i++) begin
			crcEn = 1'($urandom);
			sum += base[i/5] + 14'(i % 5);
			rp(8'(REG_CELL_BASE + 2 * i), {2'b00, base[i/5] + 14'(i % 5)});
		end
		check(stackSum, sum, "stack sum");
		rp(REG_SUM_HI, sum[17:2]);
		// start timing on a rising edge of busy, not mid-frame
		waitBusy(0);
		waitBusy(1);
		t0 = $time;
		waitBusy(0);
		waitBusy(1);
		check(32'(($time - t0) / 4), FR, "frame period");
		balanceGroup = 15'h0020;
		waitBusy(0);
		waitBusy(1);
		c0 = 0;
		c1 = 0;
		repeat (FR) begin
			c0 += adcBusy[0];
			c1 += adcBusy[1];
			@(negedge clk);
		end
		check(c0 > 3 * c1 && c1 > 0, 1'b1, "short window");
		balanceGroup = '0;
		// every fault kind: flag, alert, drive cut, no self recovery
		foreach (ks[j]) begin
			fetSet();
			check({chargeFetDrive, dischargeFetDrive}, 2'b11, "fet on");
			inject(ks[j], 1'b1);
			if (ks[j] <= ST_LOW) begin
				waitBusy(1);
				waitBusy(0);
			end
			@(negedge clk);
			check(status[ks[j]], 1'b1, "fault flag");
			check(alertOut, 1'b1, "alert");
			check({chargeFetDrive, dischargeFetDrive} == 2'b11, 1'b0, "fet cut");
			if (ks[j] == ST_EXT) check({chargeFetDrive, dischargeFetDrive}, 2'b00, "both");
			fetSet();
			check({chargeFetDrive, dischargeFetDrive} == 2'b11, 1'b0, "set refused");
			inject(ks[j], 1'b0);
			repeat (3) @(negedge clk);
			statusClear = 7'h01 << ks[j];
			@(negedge clk) statusClear = '0;
			@(negedge clk);
			check({status, alertOut}, 8'h00, "cleared");
			check({chargeFetDrive, dischargeFetDrive} == 2'b11, 1'b0, "stays off");
		end
		// converter off: no sequencing and no cell limit
		@(negedge clk) adcEnableWr = 1'b1;
		@(negedge clk) adcEnableWr = 1'b0;
		inject(ST_HIGH, 1'b1);
		repeat (2 * FR) @(negedge clk);
		check({adcEnable, adcBusy, status[ST_HIGH]}, 5'h00, "disabled");
		inject(ST_HIGH, 1'b0);
		// host write turns the converter back on
		@(negedge clk) adcEnableVal = 1'b1;
		adcEnableWr = 1'b1;
		@(negedge clk) adcEnableWr = 1'b0;
		check(adcEnable, 1'b1, "host enable");
		// integrator sample: alert, then a pair that stays one sample
		ccOld = 16'($urandom);
		ccCode = ccOld;
		@(negedge clk) ccDone = 1'b1;
		@(negedge clk) ccDone = 1'b0;
		check({status[ST_CCRDY], alertOut}, 2'b11, "cc ready");
		crcEn = 1'b1;
		host.start(REG_CC_HI);
		host.next(d, c, v);
		check(d, ccOld[15:8], "cc hi");
		ccCode = ~ccOld;
		@(negedge clk) ccDone = 1'b1;
		@(negedge clk) ccDone = 1'b0;
		host.next(d, c, v);
		check(d, ccOld[7:0], "cc lo frozen");
		host.stop();
		rp(REG_CC_HI, ~ccOld);
		rp(8'hfe, 16'h0000);
		close_out();
	end
endmodule : tb
